/* File: rtl/dlp_regs.svh */
// Register map, field positions and constants of the luma processing path
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef DLP_REGS_SVH
`define DLP_REGS_SVH

// Byte offsets on the register bus
`define DLP_OFS_CONTRAST 8'h00
`define DLP_OFS_BRIGHT   8'h04
`define DLP_OFS_BLX      8'h08
`define DLP_OFS_PEAK     8'h0c
`define DLP_OFS_SOFT1    8'h10
`define DLP_OFS_SOFT2    8'h14
`define DLP_OFS_HARD     8'h18
`define DLP_OFS_MEAS     8'h1c
`define DLP_OFS_TILT     8'h20

// Field positions
`define DLP_F_MAIN6   5:0
`define DLP_F_SIDE6   13:8
`define DLP_F_MAIN8   7:0
`define DLP_F_SIDE8   15:8
`define DLP_F_COEF    3:0
`define DLP_F_GAIN    7:4
`define DLP_F_THR     16:8
`define DLP_F_OVER    3:0
`define DLP_F_UNDER   7:4
`define DLP_F_SOFTEN  8
`define DLP_F_FSEL    9
`define DLP_F_TILT    8:0
`define DLP_F_SLOPE   15:12
`define DLP_F_LO9     8:0
`define DLP_F_HI9     24:16
`define DLP_HARD_MSB  8

// Reset values and arithmetic constants
`define DLP_CONTRAST_UNITY 6'h20
`define DLP_Y_MAX          9'h1ff
`define DLP_CONTRAST_SHIFT 5
`define DLP_COEF_SHIFT     4
`define DLP_GAIN_SHIFT     3
`define DLP_SOFT_SHIFT     4
`define DLP_PEAK_SHIFT     3
`define DLP_PEAK_CLIP      16'sh0040

`endif

/* File: rtl/dlp_pkg.sv */
// Types shared by the luma processing path
package dlp_pkg;

  //----------------------------------------------------------------------------
  // Pixel carried down the pipeline with its priority attributes
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic       vld;
    logic       side;
    logic       blx_en;
    logic       tsup;
    logic [8:0] y;
  } dlp_pix_t;

  //----------------------------------------------------------------------------
  // Software settings
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] contrast_m;
    logic [5:0] contrast_s;
    logic [7:0] bright_m;
    logic [7:0] bright_s;
    logic [3:0] tilt_coefficient;
    logic [3:0] expansion_gain;
    logic [8:0] expander_upper_threshold;
    logic [3:0] over_amt;
    logic [3:0] under_amt;
    logic       soften;
    logic       fsel;
    logic [8:0] tilt1;
    logic [3:0] slope1;
    logic [8:0] tilt2;
    logic [3:0] slope2;
    logic [8:0] hard;
  } dlp_cfg_t;

  //----------------------------------------------------------------------------
  // Whole state of the block
  //----------------------------------------------------------------------------
  typedef struct packed {
    dlp_cfg_t           cfg;
    logic [8:0]         mn;
    logic [8:0]         mx;
    logic [8:0]         lmin;
    logic [8:0]         lmax;
    logic [8:0]         lt;
    logic [8:0]         lp_prev;
    dlp_pix_t           s1;
    dlp_pix_t           s2;
    dlp_pix_t [4:0]     win;
    dlp_pix_t           s3;
    dlp_pix_t           s4;
    dlp_pix_t           s5;
    dlp_pix_t           s6;
    logic [8:0]         s5_org;
    logic [8:0]         y_out;
    logic               y_vld;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               hold;
  } dlp_state_t;

endpackage : dlp_pkg

/* File: rtl/dlp_luma.sv */
// Luma processing path: contrast, black expander, peaking, brightness, limiters
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dlp_regs.svh"

module dlp_luma
  import dlp_pkg::*;
#(
  parameter int Y_IN_W = 8
)(
  // Clock, reset, enable
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  input  wire logic              CE,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Luma in with priority attributes
  input  wire logic [Y_IN_W-1:0] Y_IN,
  input  wire logic              Y_VALID,
  input  wire logic              PRIO_SIDE,
  input  wire logic              PRIO_BLX_EN,
  input  wire logic              PRIO_TSUP_EN,
  input  wire logic              PRIO_SRC_SW,
  input  wire logic              FIELD_START,
  // Luma out
  output logic [8:0]             Y_OUT,
  output logic                   Y_OUT_VALID
);

  //----------------------------------------------------------------------------
  // Elaboration check
  //----------------------------------------------------------------------------
  // Internal scaling assumes at most eight input bits
  if (Y_IN_W < 1 || Y_IN_W > 8)
  begin : g_bad_width
    $error("Y_IN_W must lie between 1 and 8");
  end

  //----------------------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------------------
  localparam dlp_cfg_t CFG_RST = '{
    contrast_m:               `DLP_CONTRAST_UNITY,
    contrast_s:               `DLP_CONTRAST_UNITY,
    expander_upper_threshold: `DLP_Y_MAX,
    tilt1:                    `DLP_Y_MAX,
    tilt2:                    `DLP_Y_MAX,
    hard:                     `DLP_Y_MAX,
    default:                  '0
  };
  localparam dlp_state_t ST_RST = '{
    cfg:     CFG_RST,
    mn:      `DLP_Y_MAX,
    default: '0
  };

  //----------------------------------------------------------------------------
  // Arithmetic helpers
  //----------------------------------------------------------------------------
  // Clamp to the 9-bit luma range; negative results go to zero
  function automatic logic [8:0] sat9(input logic signed [15:0] v);
    if (v < 16'sh0000)
      return 9'h000;
    else if (v > $signed({7'h00, `DLP_Y_MAX}))
      return `DLP_Y_MAX;
    else
      return v[8:0];
  endfunction : sat9

  // Amount a limiter part removes: slope/16 of the excess over its tilt
  function automatic logic signed [15:0] soft_part(input logic [8:0] y,
                                                   input logic [8:0] t,
                                                   input logic [3:0] s);
    logic signed [15:0] ex;
    ex = $signed({7'h00, y}) - $signed({7'h00, t});
    if (y > t)
      return (ex * $signed({12'h000, s})) >>> `DLP_SOFT_SHIFT;
    else
      return 16'sh0000;
  endfunction : soft_part

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  dlp_state_t r;
  dlp_state_t n;
  logic       pready_c;

  // No wait state: read data are fetched into a flop at the first enabled cycle of a
  // transfer, so a clock enable low during setup stalls the access instead of hanging it
  assign pready_c = CE & r.hold & PSEL & PENABLE;

  always_comb
  begin
    logic               err;
    logic [31:0]        rd;
    dlp_pix_t           pin;
    logic [5:0]         cset;
    logic signed [15:0] prod;
    logic [8:0]         lp;
    logic [8:0]         rng;
    logic [12:0]        tprod;
    logic signed [15:0] diff;
    logic [8:0]         tap_a;
    logic [8:0]         tap_b;
    logic signed [15:0] hp;
    logic signed [15:0] hps;
    logic [3:0]         amt;
    logic signed [15:0] term;
    logic [7:0]         bset;
    err   = 1'b0;
    rd    = '0;
    pin   = '0;
    cset  = '0;
    prod  = '0;
    lp    = '0;
    rng   = '0;
    tprod = '0;
    diff  = '0;
    tap_a = '0;
    tap_b = '0;
    hp    = '0;
    hps   = '0;
    amt   = '0;
    term  = '0;
    bset  = '0;
    n     = r;

    //--------------------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------------------
    unique case (PADDR)
      `DLP_OFS_CONTRAST:
      begin
        rd[`DLP_F_MAIN6] = r.cfg.contrast_m;
        rd[`DLP_F_SIDE6] = r.cfg.contrast_s;
      end
      `DLP_OFS_BRIGHT:
      begin
        rd[`DLP_F_MAIN8] = r.cfg.bright_m;
        rd[`DLP_F_SIDE8] = r.cfg.bright_s;
      end
      `DLP_OFS_BLX:
      begin
        rd[`DLP_F_COEF] = r.cfg.tilt_coefficient;
        rd[`DLP_F_GAIN] = r.cfg.expansion_gain;
        rd[`DLP_F_THR]  = r.cfg.expander_upper_threshold;
      end
      `DLP_OFS_PEAK:
      begin
        rd[`DLP_F_OVER]   = r.cfg.over_amt;
        rd[`DLP_F_UNDER]  = r.cfg.under_amt;
        rd[`DLP_F_SOFTEN] = r.cfg.soften;
        rd[`DLP_F_FSEL]   = r.cfg.fsel;
      end
      `DLP_OFS_SOFT1:
      begin
        rd[`DLP_F_TILT]  = r.cfg.tilt1;
        rd[`DLP_F_SLOPE] = r.cfg.slope1;
      end
      `DLP_OFS_SOFT2:
      begin
        rd[`DLP_F_TILT]  = r.cfg.tilt2;
        rd[`DLP_F_SLOPE] = r.cfg.slope2;
      end
      `DLP_OFS_HARD: rd[`DLP_F_LO9] = r.cfg.hard;
      `DLP_OFS_MEAS:
      begin
        rd[`DLP_F_LO9] = r.lmin;
        rd[`DLP_F_HI9] = r.lmax;
      end
      `DLP_OFS_TILT: rd[`DLP_F_LO9] = r.lt;
      default:       err = 1'b1;
    endcase

    if (PSEL && !r.hold)
    begin
      n.hold    = 1'b1;
      n.prdata  = rd;
      n.pslverr = err;
    end
    if (pready_c)
    begin
      n.hold = 1'b0;
      if (PWRITE && !r.pslverr)
      begin
        unique case (PADDR)
          `DLP_OFS_CONTRAST:
          begin
            n.cfg.contrast_m = PWDATA[`DLP_F_MAIN6];
            n.cfg.contrast_s = PWDATA[`DLP_F_SIDE6];
          end
          `DLP_OFS_BRIGHT:
          begin
            n.cfg.bright_m = PWDATA[`DLP_F_MAIN8];
            n.cfg.bright_s = PWDATA[`DLP_F_SIDE8];
          end
          `DLP_OFS_BLX:
          begin
            n.cfg.tilt_coefficient         = PWDATA[`DLP_F_COEF];
            n.cfg.expansion_gain           = PWDATA[`DLP_F_GAIN];
            n.cfg.expander_upper_threshold = PWDATA[`DLP_F_THR];
          end
          `DLP_OFS_PEAK:
          begin
            n.cfg.over_amt  = PWDATA[`DLP_F_OVER];
            n.cfg.under_amt = PWDATA[`DLP_F_UNDER];
            n.cfg.soften    = PWDATA[`DLP_F_SOFTEN];
            n.cfg.fsel      = PWDATA[`DLP_F_FSEL];
          end
          `DLP_OFS_SOFT1:
          begin
            n.cfg.tilt1  = PWDATA[`DLP_F_TILT];
            n.cfg.slope1 = PWDATA[`DLP_F_SLOPE];
          end
          `DLP_OFS_SOFT2:
          begin
            n.cfg.tilt2  = PWDATA[`DLP_F_TILT];
            n.cfg.slope2 = PWDATA[`DLP_F_SLOPE];
          end
          `DLP_OFS_HARD:
          begin
            // Top bit forced so the ceiling cannot fall below 256
            n.cfg.hard                = PWDATA[`DLP_F_LO9];
            n.cfg.hard[`DLP_HARD_MSB] = 1'b1;
          end
          default: n.hold = 1'b0;
        endcase
      end
    end

    //--------------------------------------------------------------------------
    // Stage 1: contrast with per-pixel set selection
    //--------------------------------------------------------------------------
    pin.vld    = Y_VALID;
    pin.side   = PRIO_SIDE;
    pin.blx_en = PRIO_BLX_EN;
    pin.tsup   = PRIO_TSUP_EN & PRIO_SRC_SW;
    cset       = PRIO_SIDE ? r.cfg.contrast_s : r.cfg.contrast_m;
    prod       = $signed(16'(Y_IN)) * $signed({10'h000, cset});
    pin.y      = sat9(prod >>> `DLP_CONTRAST_SHIFT);
    n.s1       = pin;

    //--------------------------------------------------------------------------
    // Stage 2: black level expander and its field measurement
    //--------------------------------------------------------------------------
    // Two-tap average halves single-sample noise spikes before they reach the min/max
    lp = 9'(({1'b0, r.s1.y} + {1'b0, r.lp_prev}) >> 1);
    if (r.s1.vld)
    begin
      n.lp_prev = r.s1.y;
      if (lp < r.mn)
        n.mn = lp;
      if (lp > r.mx)
        n.mx = lp;
    end
    rng   = r.mx - r.mn;
    tprod = 13'(r.cfg.tilt_coefficient) * 13'(rng);
    if (FIELD_START)
    begin
      // A field without samples keeps the old tilt
      if (r.mx >= r.mn)
      begin
        n.lmin = r.mn;
        n.lmax = r.mx;
        n.lt   = 9'(r.mn + 9'(tprod >> `DLP_COEF_SHIFT));
      end
      n.mn = `DLP_Y_MAX;
      n.mx = '0;
    end
    n.s2 = r.s1;
    if (r.s1.blx_en && r.s1.y < r.lt &&
        r.s1.y <= r.cfg.expander_upper_threshold)
    begin
      diff   = $signed({7'h00, r.s1.y}) - $signed({7'h00, r.lt});
      n.s2.y = sat9($signed({7'h00, r.s1.y}) +
                    ((diff * $signed({12'h000, r.cfg.expansion_gain})) >>> `DLP_GAIN_SHIFT));
    end

    //--------------------------------------------------------------------------
    // Stage 3: dynamic peaking on the window centre
    //--------------------------------------------------------------------------
    n.win = {r.win[3:0], r.s2};
    // Wide tap spacing puts the peak lower in frequency
    tap_a = r.cfg.fsel ? r.win[1].y : r.win[0].y;
    tap_b = r.cfg.fsel ? r.win[3].y : r.win[4].y;
    hp    = $signed({6'h00, r.win[2].y, 1'b0}) - $signed({7'h00, tap_a}) -
            $signed({7'h00, tap_b});
    // Clipping the detail bounds the correction, so big edges stay nearly untouched
    if (hp > `DLP_PEAK_CLIP)
      hps = `DLP_PEAK_CLIP;
    else if (hp < -`DLP_PEAK_CLIP)
      hps = -`DLP_PEAK_CLIP;
    else
      hps = hp;
    amt  = (hp >= 16'sh0000) ? r.cfg.over_amt : r.cfg.under_amt;
    term = (hps * 16'($signed(amt))) >>> `DLP_PEAK_SHIFT;
    if (r.cfg.soften)
      term = -term;
    if (r.win[2].tsup)
      term = 16'sh0000;
    n.s3   = r.win[2];
    n.s3.y = sat9($signed({7'h00, r.win[2].y}) + term);

    //--------------------------------------------------------------------------
    // Stage 4: brightness, doubled so 8 bits span the whole 9-bit range
    //--------------------------------------------------------------------------
    bset   = r.s3.side ? r.cfg.bright_s : r.cfg.bright_m;
    n.s4   = r.s3;
    n.s4.y = sat9($signed({7'h00, r.s3.y}) + (16'($signed(bset)) <<< 1));

    //--------------------------------------------------------------------------
    // Stages 5 to 7: soft limiter parts and hard clip
    //--------------------------------------------------------------------------
    n.s5     = r.s4;
    n.s5_org = r.s4.y;
    n.s5.y   = sat9($signed({7'h00, r.s4.y}) -
                    soft_part(r.s4.y, r.cfg.tilt1, r.cfg.slope1));
    // Part two works on the limiter input, so steep slopes can fold the curve
    n.s6     = r.s5;
    n.s6.y   = sat9($signed({7'h00, r.s5.y}) -
                    soft_part(r.s5_org, r.cfg.tilt2, r.cfg.slope2));
    n.y_out  = (r.s6.y > r.cfg.hard) ? r.cfg.hard : r.s6.y;
    n.y_vld  = r.s6.vld;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
      r <= ST_RST;
    else if (CE)
      r <= n;
  end

  assign PRDATA      = r.prdata;
  assign PREADY      = pready_c;
  assign PSLVERR     = pready_c & r.pslverr;
  assign Y_OUT       = r.y_out;
  assign Y_OUT_VALID = r.y_vld;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence seq_run;
    CE [*8];
  endsequence

  a_contrast_unity: assert property ((CE && Y_VALID && !PRIO_SIDE &&
      r.cfg.contrast_m == `DLP_CONTRAST_UNITY) |=> r.s1.y == 9'($past(Y_IN)))
    else $error("unity contrast changed the sample");
  a_tilt_range: assert property ((r.lmax >= r.lmin) |->
      (r.lt >= r.lmin && r.lt <= r.lmax))
    else $error("tilt point outside measured range");
  a_blx_pass_above: assert property ((CE && r.s1.y >= r.lt) |=>
      r.s2.y == $past(r.s1.y))
    else $error("expander altered a sample above tilt");
  a_blx_thr_pass: assert property ((CE && r.s1.y > r.cfg.expander_upper_threshold) |=>
      r.s2.y == $past(r.s1.y))
    else $error("expander altered a sample above threshold");
  a_peak_suppress: assert property ((CE && r.win[2].tsup) |=>
      r.s3.y == $past(r.win[2].y))
    else $error("peaking not suppressed on source switch");
  a_soft_below: assert property ((CE && r.s4.y <= r.cfg.tilt1) |=>
      r.s5.y == $past(r.s4.y))
    else $error("limiter part one altered a sample below tilt");
  a_hard_ceiling: assert property (Y_OUT_VALID |-> Y_OUT <= r.cfg.hard)
    else $error("output above hard ceiling");
  a_tilt_field: assert property ($changed(r.lt) |-> $past(FIELD_START && CE))
    else $error("tilt point changed inside a field");
  a_pipe_latency: assert property ((CE && Y_VALID) ##1 seq_run ##1 CE |=>
      Y_OUT_VALID)
    else $error("sample did not leave after ten stages");
  a_apb_ready: assert property ((PSEL && !PENABLE && CE) ##1 (PSEL && PENABLE && CE)
      |-> PREADY)
    else $error("access phase not answered");

endmodule : dlp_luma
`default_nettype wire

/* File: verif/dlp_src.sv */
// Front-end source model streaming luma samples with priority attributes
`timescale 1ns/1ps
`default_nettype none
module dlp_src
(
  // Clock
  input  wire logic  clk,
  // Sample stream, attr is field start, side, expander, suppress, switch
  output logic [7:0] y,
  output logic       vld,
  output logic [4:0] attr,
  output int         t_in
);
  //----------------------------------------------------------------------------
  // Queue of samples, one taken per clock
  //----------------------------------------------------------------------------
  logic [12:0] q[$];
  int          cyc = 0;

  initial
  begin
    y = 8'h00;
    vld = 1'b0;
    attr = 5'h00;
    t_in = 0;
  end

  task automatic push(input logic [12:0] e);
    q.push_back(e);
  endtask : push

  // Idle data toggles so a stale sample can never pass for a held one
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (q.size() != 0)
    begin
      {attr, y} <= q.pop_front();
      vld <= 1'b1;
      t_in <= cyc;
    end
    else
    begin
      y <= ~y;
      vld <= 1'b0;
      attr <= 5'h00;
    end
  end
endmodule : dlp_src
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking testbench of the luma processing path
`timescale 1ns/1ps
`default_nettype none
`include "dlp_regs.svh"
module testbench;
  //----------------------------------------------------------------------------
  // Signals and instances
  //----------------------------------------------------------------------------
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        yv;
  logic        ov;
  logic        er;
  logic [7:0]  paddr;
  logic [7:0]  y;
  logic [4:0]  at;
  logic [8:0]  yo;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [8:0]  q[$];
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t_out = 0;
  int          t_in;
  logic [7:0]  ofs[9] = '{`DLP_OFS_CONTRAST, `DLP_OFS_BRIGHT, `DLP_OFS_BLX, `DLP_OFS_PEAK,
                           `DLP_OFS_SOFT1, `DLP_OFS_SOFT2, `DLP_OFS_HARD, `DLP_OFS_MEAS,
                           `DLP_OFS_TILT};
  logic [31:0] rstv[9] = '{32'h2020, 32'h0, 32'h1ff00, 32'h0, 32'h1ff, 32'h1ff, 32'h1ff,
                           32'h0, 32'h0};

  dlp_src u_src (.clk(clk), .y(y), .vld(yv), .attr(at), .t_in(t_in));

  dlp_luma #(.Y_IN_W(8)) u_dut (
    .SYS_CLK(clk), .RST_B(rst_b), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .Y_IN(y), .Y_VALID(yv), .PRIO_SIDE(at[3]), .PRIO_BLX_EN(at[2]),
    .PRIO_TSUP_EN(at[1]), .PRIO_SRC_SW(at[0]), .FIELD_START(at[4]), .Y_OUT(yo),
    .Y_OUT_VALID(ov));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Output monitor and hang guard; tests need under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ov === 1'b1)
    begin
      q.push_back(yo);
      t_out <= cyc;
    end
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic px(input logic [7:0] v, input int n, input logic [4:0] a);
    repeat (n) u_src.push({a, v});
  endtask : px

  task automatic drain;
    while (u_src.q.size() != 0)
      @(posedge clk);
    repeat (14) @(posedge clk);
  endtask : drain

  // Flat run of samples; the middle one is far from the run's edges
  task automatic yck(input logic [7:0] v, input logic [4:0] a, input logic [8:0] e);
    q.delete();
    px(v, 12, a);
    drain();
    chk(32'(q.size()), 32'd12);
    chk({23'h0, q[5]}, {23'h0, e});
  endtask : yck

  //----------------------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rstv[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `DLP_OFS_CONTRAST, 32'h1020);
    yck(8'd100, 5'h00, 9'd100);
    yck(8'd100, 5'h08, 9'd50);
    apb(1'b1, `DLP_OFS_CONTRAST, 32'h103f);
    yck(8'd255, 5'h00, 9'd502);
    apb(1'b1, `DLP_OFS_CONTRAST, 32'h2020);
    apb(1'b1, `DLP_OFS_BRIGHT, 32'h7f80);
    yck(8'd100, 5'h00, 9'd0);
    yck(8'd100, 5'h08, 9'd354);
    apb(1'b1, `DLP_OFS_SOFT1, 32'h8064);
    yck(8'd46, 5'h08, 9'd200);
    apb(1'b1, `DLP_OFS_SOFT2, 32'hc064);
    yck(8'd46, 5'h08, 9'd50);
    yck(8'd86, 5'h08, 9'd40);
    apb(1'b1, `DLP_OFS_SOFT1, 32'h1ff);
    apb(1'b1, `DLP_OFS_SOFT2, 32'h1ff);
    apb(1'b1, `DLP_OFS_HARD, 32'h0);
    yck(8'd100, 5'h08, 9'd256);
    apb(1'b0, `DLP_OFS_HARD, 32'h0);
    chk(rd, 32'h100);
    apb(1'b1, `DLP_OFS_HARD, 32'h1ff);
    apb(1'b1, `DLP_OFS_BRIGHT, 32'h0);
    // Expander: one field of 100 and 200 gives range 100, tilt 150
    apb(1'b1, `DLP_OFS_BLX, 32'h1ff88);
    px(8'd100, 20, 5'h00);
    px(8'd100, 1, 5'h10);
    px(8'd100, 10, 5'h00);
    px(8'd200, 10, 5'h00);
    px(8'd100, 10, 5'h00);
    px(8'd100, 1, 5'h10);
    drain();
    apb(1'b0, `DLP_OFS_MEAS, 32'h0);
    chk(rd, 32'h00c80064);
    apb(1'b0, `DLP_OFS_TILT, 32'h0);
    chk(rd, 32'h96);
    yck(8'd120, 5'h04, 9'd90);
    yck(8'd150, 5'h04, 9'd150);
    yck(8'd120, 5'h00, 9'd120);
    apb(1'b1, `DLP_OFS_BLX, 32'h06e88);
    yck(8'd120, 5'h04, 9'd120);
    // Peaking on an impulse: sharpen lifts it, soften lowers it
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `DLP_OFS_PEAK, {22'h0, k[1:0], 8'h37});
      q.delete();
      px(8'd100, 8, k[2] ? 5'h03 : 5'h00);
      px(8'd180, 1, k[2] ? 5'h03 : 5'h00);
      px(8'd100, 8, k[2] ? 5'h03 : 5'h00);
      drain();
      if (k < 4)
      begin
        chk({23'h0, q[8]}, k[0] ? 32'd124 : 32'd236);
        chk({23'h0, q[k[1] ? 7 : 6]}, k[0] ? 32'd124 : 32'd76);
        chk({23'h0, q[k[1] ? 6 : 7]}, 32'd100);
      end
      else
        chk({14'h0, q[7], q[8]}, {14'h0, 9'd100, 9'd180});
    end
    apb(1'b1, `DLP_OFS_PEAK, 32'h0);
    q.delete();
    px(8'd90, 1, 5'h00);
    drain();
    chk(32'(t_out - t_in), 32'd11);
    chk(32'(q.size()), 32'd1);
    // Clock enable low freezes the pipe and stalls a bus read begun meanwhile
    q.delete();
    px(8'd90, 1, 5'h00);
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    fork
      apb(1'b0, `DLP_OFS_TILT, 32'h0);
      begin
        repeat (5) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(rd, 32'h96);
    drain();
    chk(32'(t_out - t_in), 32'd16);
    chk(32'(q.size()), 32'd1);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
